// >>> verilog/gprf_pkg.sv
// package: constants and carriers for the general register file block
package gprf_pkg;
  localparam int XLEN = 32;
  localparam int NREG = 32;
  localparam logic [4:0] ZERO_REG = 5'h00;
  localparam logic [4:0] LINK_REG = 5'h1f;
  localparam logic [31:0] LINK_OFFSET = 32'h00000008; // two instructions past the call
  localparam int MUL_CLOCKS = 12;
  localparam int DIV_CLOCKS = 35;
  localparam logic [5:0] MUL_CYCLES = 6'(MUL_CLOCKS);
  localparam logic [5:0] DIV_CYCLES = 6'(DIV_CLOCKS);
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam logic [5:0] CNT_ZERO = 6'h00;

  // kind of general register write
  typedef enum logic [1:0] {
    GPRF_WR_NONE = 2'h0,
    GPRF_WR_DATA = 2'h1,
    GPRF_WR_CALL = 2'h2,
    GPRF_WR_CALLR = 2'h3
  } gprf_wrkind_t;

  // multiply/divide unit operations
  typedef enum logic [2:0] {
    GPRF_MD_NONE = 3'h0,
    GPRF_MD_MULS = 3'h1,
    GPRF_MD_MULU = 3'h2,
    GPRF_MD_DIVS = 3'h3,
    GPRF_MD_DIVU = 3'h4,
    GPRF_MD_SETUP = 3'h5,
    GPRF_MD_SETLO = 3'h6
  } gprf_mdop_t;

  // result-register move-out selector
  typedef enum logic [1:0] {
    GPRF_MF_NONE = 2'h0,
    GPRF_MF_UPPER = 2'h1,
    GPRF_MF_BOTTOM = 2'h2
  } gprf_mfsel_t;

  // writeback request from the pipeline
  typedef struct packed {
    gprf_wrkind_t kind;
    logic [4:0] addr;
    logic [31:0] data;
    logic [31:0] pc;
  } gprf_wr_t;

  // multiply/divide unit request
  typedef struct packed {
    gprf_mdop_t op;
    logic [4:0] srcA;
    logic [4:0] srcB;
  } gprf_md_t;

  // float coprocessor data-register access
  typedef struct packed {
    logic wrEn;
    logic wrDouble;
    logic arith;
    logic [4:0] addr;
    logic [63:0] data;
  } gprf_fp_t;

  // multiply/divide state machine, one-hot
  typedef enum logic [1:0] {
    GPRF_IDLE = 2'b01,
    GPRF_BUSY = 2'b10
  } gprf_mdst_t;
endpackage : gprf_pkg

// >>> verilog/gprf_core.sv
// general register file with private multiply/divide result registers and float data registers
`timescale 1ns/1ps

// Summary of operation
// - reading general register zero always yields zero
// - writes naming register zero are accepted and discarded silently
// - immediate call writes its return address into register thirty-one
// - register-indirect call writes return address into the named register
// - return address is call address plus two instructions
// - no condition-code flags are kept anywhere in the datapath
// - multiply forms 64-bit product split into upper and bottom registers
// - divide leaves quotient and remainder in the same result pair
// - move-out instructions copy upper or bottom register into a general register
// - a move-out during a busy multiply or divide stalls until done
// - float coprocessor has 32 data registers, sixteen even ones for arithmetic
// - even float registers serve single or double precision values
// - for doubles, register N+1 holds remaining bits of even register N
// - odd float registers only reached by moves, loads and stores
// - register number selects float or integer file by instruction
// - coprocessor control registers form a separate set from data registers
// - after divide, bottom holds quotient and upper holds remainder
// - multiply completes after 12 clocks, divide after 35 clocks
// - results land in result registers when ready, not at writeback
// - move-in instructions load upper and bottom from general registers
module gprf_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] rdAddrA,
  input wire logic [4:0] rdAddrB,
  output logic [31:0] rdDataA,
  output logic [31:0] rdDataB,
  input wire gprf_pkg::gprf_wr_t wrReq,
  input wire gprf_pkg::gprf_md_t mdReq,
  input wire gprf_pkg::gprf_mfsel_t mfSel,
  output logic mdStall,
  output logic [31:0] mfData,
  output logic mdBusy,
  input wire gprf_pkg::gprf_fp_t fpReq,
  input wire logic [4:0] fpRdAddr,
  input wire logic fpRdArith,
  output logic [63:0] fpRdData,
  output logic fpAddrFault,
  input wire logic fpCtlWrEn,
  input wire logic [4:0] fpCtlAddr,
  input wire logic [31:0] fpCtlWrData,
  output logic [31:0] fpCtlRdData
);
  import gprf_pkg::*;

  // whole module state
  typedef struct packed {
    logic [NREG-1:0][31:0] gpr;
    logic [NREG-1:0][31:0] fpr;
    logic [NREG-1:0][31:0] fpCtl;
    logic [31:0] upper;
    logic [31:0] bottom;
    logic [63:0] pending;
    logic [5:0] count;
    gprf_mdst_t st;
    logic [31:0] mfOut;
    logic [63:0] fpOut;
    logic [31:0] ctlOut;
  } gprf_state_t;

  gprf_state_t s_q;
  gprf_state_t s_d;

  logic wrActive;
  logic [4:0] wrAddr;
  logic [31:0] wrData;
  logic [31:0] opA;
  logic [31:0] opB;
  logic [63:0] mulS;
  logic [63:0] mulU;
  logic [63:0] divS;
  logic [63:0] divU;

  // decode the single write port: data, fixed-link call or named-link call
  always_comb
  begin
    wrAddr = wrReq.addr;
    wrData = wrReq.data;
    wrActive = 1'b0;
    unique case (wrReq.kind)
      GPRF_WR_NONE: wrActive = 1'b0;
      GPRF_WR_DATA: wrActive = 1'b1;
      GPRF_WR_CALL:
      begin
        wrActive = 1'b1;
        wrAddr = LINK_REG;
        wrData = wrReq.pc + LINK_OFFSET;
      end
      GPRF_WR_CALLR:
      begin
        wrActive = 1'b1;
        wrData = wrReq.pc + LINK_OFFSET;
      end
    endcase
    if (wrAddr == ZERO_REG)
    begin
      wrActive = 1'b0;
    end
  end

  // two read ports with same-cycle bypass; register zero reads as zero
  always_comb
  begin
    if (rdAddrA == ZERO_REG)
    begin
      rdDataA = RESET_WORD;
    end
    else if (wrActive && wrAddr == rdAddrA)
    begin
      rdDataA = wrData;
    end
    else
    begin
      rdDataA = s_q.gpr[rdAddrA];
    end
    if (rdAddrB == ZERO_REG)
    begin
      rdDataB = RESET_WORD;
    end
    else if (wrActive && wrAddr == rdAddrB)
    begin
      rdDataB = wrData;
    end
    else
    begin
      rdDataB = s_q.gpr[rdAddrB];
    end
  end

  // operands for the multiply/divide unit come straight from the read ports
  assign opA = rdDataA;
  assign opB = rdDataB;

  // precomputed results; {remainder, quotient} for divides, no flags kept
  always_comb
  begin
    mulS = $signed(opA) * $signed(opB);
    mulU = opA * opB;
    divS = 64'h0000000000000000;
    divU = 64'h0000000000000000;
    if (opB != RESET_WORD)
    begin
      divS = {32'($signed(opA) % $signed(opB)), 32'($signed(opA) / $signed(opB))};
      divU = {opA % opB, opA / opB};
    end
  end

  // move-out stalls while the unit is busy; no status state touches ALU ops
  assign mdBusy = (s_q.st == GPRF_BUSY);
  assign mdStall = mdBusy && (mfSel != GPRF_MF_NONE);
  assign mfData = s_q.mfOut;
  assign fpRdData = s_q.fpOut;
  assign fpCtlRdData = s_q.ctlOut;
  // odd float registers are illegal as arithmetic operands or results
  assign fpAddrFault = (fpRdArith && fpRdAddr[0]) || (fpReq.wrEn && fpReq.arith && fpReq.addr[0]);

  // next-state logic
  always_comb
  begin
    s_d = s_q;
    // general register write; register zero never stored
    if (wrActive)
    begin
      s_d.gpr[wrAddr] = wrData;
    end
    s_d.gpr[ZERO_REG] = RESET_WORD;

    // multiply/divide sequencing
    unique case (s_q.st)
      GPRF_IDLE:
      begin
        unique case (mdReq.op)
          GPRF_MD_MULS:
          begin
            s_d.pending = mulS;
            s_d.count = MUL_CYCLES - 6'h01;
            s_d.st = GPRF_BUSY;
          end
          GPRF_MD_MULU:
          begin
            s_d.pending = mulU;
            s_d.count = MUL_CYCLES - 6'h01;
            s_d.st = GPRF_BUSY;
          end
          GPRF_MD_DIVS:
          begin
            s_d.pending = divS;
            s_d.count = DIV_CYCLES - 6'h01;
            s_d.st = GPRF_BUSY;
          end
          GPRF_MD_DIVU:
          begin
            s_d.pending = divU;
            s_d.count = DIV_CYCLES - 6'h01;
            s_d.st = GPRF_BUSY;
          end
          GPRF_MD_SETUP: s_d.upper = opA;
          GPRF_MD_SETLO: s_d.bottom = opA;
          default: s_d.st = GPRF_IDLE;
        endcase
      end
      GPRF_BUSY:
      begin
        if (s_q.count == CNT_ZERO)
        begin
          s_d.upper = s_q.pending[63:32];
          s_d.bottom = s_q.pending[31:0];
          s_d.st = GPRF_IDLE;
        end
        else
        begin
          s_d.count = s_q.count - 6'h01;
        end
      end
      default: s_d.st = GPRF_IDLE;
    endcase

    // move-out delivers final value once not stalled
    if (!mdStall)
    begin
      unique case (mfSel)
        GPRF_MF_UPPER: s_d.mfOut = s_q.upper;
        GPRF_MF_BOTTOM: s_d.mfOut = s_q.bottom;
        default: s_d.mfOut = s_q.mfOut;
      endcase
    end

    // float data registers: single writes one word, double to an even address writes the pair
    if (fpReq.wrEn && !(fpReq.arith && fpReq.addr[0]))
    begin
      s_d.fpr[fpReq.addr] = fpReq.data[31:0];
      if (fpReq.wrDouble && !fpReq.addr[0])
      begin
        s_d.fpr[{fpReq.addr[4:1], 1'b1}] = fpReq.data[63:32];
      end
    end
    // float read: pair {N+1, N} on even address
    s_d.fpOut = {s_q.fpr[{fpRdAddr[4:1], 1'b1}], s_q.fpr[fpRdAddr]};
    if (fpRdAddr[0])
    begin
      s_d.fpOut = {32'h00000000, s_q.fpr[fpRdAddr]};
    end

    // coprocessor control set, apart from the data file
    if (fpCtlWrEn)
    begin
      s_d.fpCtl[fpCtlAddr] = fpCtlWrData;
    end
    s_d.ctlOut = s_q.fpCtl[fpCtlAddr];
  end

  // state register; file contents left as-is across reset
  always_ff @(posedge sys_clk)
  begin
    s_q <= s_d;
    if (rst)
    begin
      s_q.gpr[ZERO_REG] <= RESET_WORD;
      s_q.st <= GPRF_IDLE;
      s_q.count <= CNT_ZERO;
      s_q.mfOut <= RESET_WORD;
      s_q.fpOut <= 64'h0000000000000000;
      s_q.ctlOut <= RESET_WORD;
    end
  end
endmodule : gprf_core

// >>> bench/gprf_core_props.sv
// port assertions for the general register file
`timescale 1ns/1ps
module gprf_core_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] rdAddrA,
  input wire logic [4:0] rdAddrB,
  input wire logic [31:0] rdDataA,
  input wire logic [31:0] rdDataB,
  input wire gprf_pkg::gprf_wr_t wrReq,
  input wire gprf_pkg::gprf_md_t mdReq,
  input wire gprf_pkg::gprf_mfsel_t mfSel,
  input wire logic mdStall,
  input wire logic [31:0] mfData,
  input wire logic mdBusy,
  input wire gprf_pkg::gprf_fp_t fpReq,
  input wire logic [4:0] fpRdAddr,
  input wire logic fpRdArith,
  input wire logic fpAddrFault
);
  import gprf_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // read ports, bypass and link writes
  property p_zero; rdAddrA == ZERO_REG |-> rdDataA == RESET_WORD; endproperty
  a_zero: assert property (p_zero) else $error("register zero read nonzero");
  property p_byp;
    wrReq.kind == GPRF_WR_DATA && wrReq.addr != ZERO_REG && rdAddrA == wrReq.addr
      |-> rdDataA == wrReq.data;
  endproperty
  a_byp: assert property (p_byp) else $error("write bypass wrong");
  property p_link;
    wrReq.kind == GPRF_WR_CALL && rdAddrB == LINK_REG |-> rdDataB == wrReq.pc + LINK_OFFSET;
  endproperty
  a_link: assert property (p_link) else $error("link value wrong");
  // multiply and divide latency
  property p_mul;
    !mdBusy && mdReq.op inside {GPRF_MD_MULS, GPRF_MD_MULU}
      |=> mdBusy [*8] ##1 mdBusy [*4] ##1 !mdBusy;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply latency wrong");
  property p_div;
    !mdBusy && mdReq.op inside {GPRF_MD_DIVS, GPRF_MD_DIVU} |-> ##35 mdBusy ##1 !mdBusy;
  endproperty
  a_div: assert property (p_div) else $error("divide latency wrong");
  // interlock on move-out
  property p_stall; mdBusy && mfSel != GPRF_MF_NONE |-> mdStall; endproperty
  a_stall: assert property (p_stall) else $error("no stall while busy");
  property p_hold; mdStall |=> $stable(mfData); endproperty
  a_hold: assert property (p_hold) else $error("move-out data during stall");
  // odd float registers refused as arithmetic operands
  property p_fault;
    (fpReq.wrEn && fpReq.arith && fpReq.addr[0]) || (fpRdArith && fpRdAddr[0]) |-> fpAddrFault;
  endproperty
  a_fault: assert property (p_fault) else $error("odd arithmetic access unflagged");
endmodule : gprf_core_props
bind gprf_core gprf_core_props u_gprf_core_props (.*);

// >>> bench/gprf_pipe_model.sv
// pipeline stand-in that holds a move-out request while stalled
`timescale 1ns/1ps
module gprf_pipe_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic mdStall,
  input wire gprf_pkg::gprf_mfsel_t wantSel,
  output gprf_pkg::gprf_mfsel_t mfSel
);
  import gprf_pkg::*;
  // request only advances when the interlock releases it
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mfSel <= GPRF_MF_NONE;
    else if (!mdStall)
      mfSel <= wantSel;
  end
endmodule : gprf_pipe_model

// >>> bench/tb.sv
// self-checking bench for the register file
`timescale 1ns/1ps
module tb;
  import gprf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] rdAddrA = '0, rdAddrB = '0, fpRdAddr = '0, fpCtlAddr = '0;
  logic [31:0] rdDataA, rdDataB, mfData, fpCtlRdData, fpCtlWrData = '0;
  logic mdStall, mdBusy, fpAddrFault, fpRdArith = 1'b0, fpCtlWrEn = 1'b0;
  logic [63:0] fpRdData, hilo = '0, v;
  gprf_wr_t wrReq = '0;
  gprf_md_t mdReq = '0;
  gprf_fp_t fpReq = '0;
  gprf_mfsel_t mfSel, wantSel = GPRF_MF_NONE;
  logic [31:0] regs [32];
  int n_fail = 0, check_count = 0;
  gprf_core u_gprf_core (.*);
  gprf_pipe_model u_gprf_pipe_model (.*);
  // clock
  initial forever #50 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic conclude();
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  // one writeback, then read the target and the link register back
  task automatic wr(input gprf_wrkind_t k, input logic [4:0] a, input logic [31:0] d);
    logic [4:0] t;
    logic [31:0] pc;
    pc = $urandom;
    t = (k == GPRF_WR_CALL) ? LINK_REG : a;
    if (t != ZERO_REG)
      regs[t] = (k == GPRF_WR_DATA) ? d : pc + LINK_OFFSET;
    @(posedge sys_clk);
    wrReq <= '{k, a, d, pc};
    rdAddrA <= t;
    rdAddrB <= LINK_REG;
    @(posedge sys_clk);
    wrReq.kind <= GPRF_WR_NONE;
    @(negedge sys_clk);
    chk("gpr", {32'h0, regs[t]}, {32'h0, rdDataA});
    chk("link", {32'h0, regs[LINK_REG]}, {32'h0, rdDataB});
  endtask : wr
  // one multiply/divide unit operation, then move both halves out
  task automatic md(input gprf_mdop_t op, input logic [4:0] ra, input logic [4:0] rb);
    logic [31:0] a, b;
    a = regs[ra];
    b = regs[rb];
    case (op)
      GPRF_MD_MULS: hilo = $signed(a) * $signed(b);
      GPRF_MD_MULU: hilo = a * b;
      GPRF_MD_DIVS: hilo = {$signed(a) % $signed(b), $signed(a) / $signed(b)};
      GPRF_MD_DIVU: hilo = {a % b, a / b};
      GPRF_MD_SETUP: hilo[63:32] = a;
      default: hilo[31:0] = a;
    endcase
    @(posedge sys_clk);
    wantSel <= GPRF_MF_NONE;
    repeat (2) @(posedge sys_clk);
    mdReq <= '{op, ra, rb};
    rdAddrA <= ra;
    rdAddrB <= rb;
    wantSel <= GPRF_MF_BOTTOM;
    @(posedge sys_clk);
    mdReq.op <= GPRF_MD_NONE;
    @(negedge sys_clk);
    if (op < GPRF_MD_SETUP)
      chk("stall", 64'h1, {63'h0, mdStall});
    for (int i = 0; i < 60 && mdBusy !== 1'b0; i++)
      @(negedge sys_clk);
    @(posedge sys_clk);
    wantSel <= GPRF_MF_UPPER;
    @(negedge sys_clk);
    chk("bottom", {32'h0, hilo[31:0]}, {32'h0, mfData});
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("upper", {32'h0, hilo[63:32]}, {32'h0, mfData});
  endtask : md
  // float write plus control write, then read back both sets
  task automatic fpx(input logic dbl, input logic ar, input logic [4:0] a, input logic [63:0] d,
    input logic [4:0] ra, input logic [63:0] e);
    @(posedge sys_clk);
    fpReq <= '{1'b1, dbl, ar, a, d};
    fpRdAddr <= ra;
    fpRdArith <= ar;
    fpCtlWrEn <= 1'b1;
    fpCtlAddr <= a;
    fpCtlWrData <= ~d[31:0];
    @(negedge sys_clk);
    chk("fault", {63'h0, ar & (a[0] | ra[0])}, {63'h0, fpAddrFault});
    @(posedge sys_clk);
    fpReq.wrEn <= 1'b0;
    fpRdArith <= 1'b0;
    fpCtlWrEn <= 1'b0;
    // read data is registered from the file as it stood, so look one edge later
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("fpr", e, fpRdData);
    chk("ctl", {32'h0, ~d[31:0]}, {32'h0, fpCtlRdData});
  endtask : fpx
  // main sequence
  initial
  begin
    void'($urandom(94510));
    regs[0] = '0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (int r = 1; r < 32; r++)
      wr(GPRF_WR_DATA, 5'(r), $urandom);
    wr(GPRF_WR_DATA, ZERO_REG, 32'hffffffff);
    wr(GPRF_WR_CALLR, ZERO_REG, 32'h0);
    for (int n = 0; n < 40; n++)
      wr(gprf_wrkind_t'($urandom_range(1, 3)), 5'($urandom), $urandom);
    for (int o = 1; o < 7; o++)
      md(gprf_mdop_t'(o), 5'($urandom_range(1, 31)), 5'($urandom_range(1, 31)));
    v = {$urandom, $urandom};
    fpx(1'b0, 1'b0, 5'h07, v, 5'h07, {32'h0, v[31:0]});
    fpx(1'b0, 1'b1, 5'h07, ~v, 5'h07, {32'h0, v[31:0]});
    fpx(1'b1, 1'b1, 5'h04, v, 5'h04, v);
    fpx(1'b0, 1'b1, 5'h0a, ~v, 5'h05, {32'h0, v[63:32]});
    conclude();
  end
  // watchdog against a hung interlock
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule : tb
